// ---- hdl/nsm_top.sv ----
// Execution unit for nibble swap and inverted mask test instructions
`timescale 1ns/1ps
`include "nsm_consts.svh"
module nsm_top (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       SRST,
  // Instruction issue from decoder; operands already fetched
  input  wire logic       START,
  input  wire logic [7:0] OPCODE,
  input  wire logic [7:0] DST_IN,
  input  wire logic [7:0] SRC_IN,
  input  wire logic [7:0] FLAGS_IN,
  // Results
  output logic            BUSY,
  output logic            DONE,
  output logic            ACCEPT,
  output logic [1:0]      LEN,
  output logic [2:0]      CYCLES,
  output logic            WR_EN,
  output logic [7:0]      WR_DATA,
  output logic [7:0]      FLAGS_OUT
);
  // Timing seen by the core: an issue is taken on the edge that samples START,
  // ACCEPT and the results show one cycle later, and DONE, with WR_EN for a swap only, shows
  // when the instruction's cycle count has run out. One idle cycle follows
  // DONE, so the earliest next issue is one cycle after the DONE pulse.

  // Decode result travels over the interface so its three fields stay together
  nsm_dec_if dif ();

  nsm_decode u_dec (
    .opcode (OPCODE),
    .d      (dif.dec)
  );

  // Sequencer state
  nsm_pkg::nsm_state_t st_q, st_d;
  logic [2:0]          cnt_q, cnt_d;
  logic                busy_q, busy_d;
  logic                done_q, done_d;
  logic                kind_swap_q, kind_swap_d;

  // Result registers, each one seen directly at a port
  logic                acc_q, acc_d;
  logic [1:0]          len_q, len_d;
  logic [2:0]          cyc_q, cyc_d;
  logic                wr_q, wr_d;
  logic [7:0]          wd_q, wd_d;
  logic [7:0]          fl_q, fl_d;

  // Combinational values of the issue cycle
  logic                take;
  logic [7:0]          swp;
  logic [7:0]          tst;

  // Flags after a swap; carry and overflow keep their old value, which is
  // allowed because software must treat them as undefined after a swap
  function automatic logic [7:0] swap_flags(input logic [7:0] res, input logic [7:0] fin);
    logic [7:0] f;
    f              = fin;
    f[`NSM_FLAG_Z] = (res == `NSM_BYTE_ZERO);
    f[`NSM_FLAG_S] = res[`NSM_SIGN_BIT];
    return f;
  endfunction

  // Flags after an inverted mask test; zero and sign follow the result, overflow always clears, the rest keep
  function automatic logic [7:0] mask_flags(input logic [7:0] res, input logic [7:0] fin);
    logic [7:0] f;
    f              = fin;
    f[`NSM_FLAG_Z] = (res == `NSM_BYTE_ZERO);
    f[`NSM_FLAG_S] = res[`NSM_SIGN_BIT];
    f[`NSM_FLAG_V] = 1'b0;
    return f;
  endfunction

  // An issue is taken only from idle and only for an opcode the decoder knows;
  // anything else is dropped without an accept pulse
  assign take = START && (st_q == nsm_pkg::NSM_IDLE) && (dif.kind != nsm_pkg::NSM_K_NONE);

  // Both results formed from the operands of the issue cycle
  assign swp = {DST_IN[3:0], DST_IN[7:4]};
  assign tst = (~DST_IN) & SRC_IN;

  // Sequencer next state: counts the instruction's cycles down after issue.
  // Results are latched at issue, so the core may change the operands while
  // the unit is busy without disturbing the outcome.
  always_comb
  begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    kind_swap_d = kind_swap_q;
    done_d      = 1'b0;
    unique case (st_q)
      nsm_pkg::NSM_IDLE:
      begin
        if (take)
        begin
          cnt_d       = dif.cycles - `NSM_CYC_ONE;
          kind_swap_d = (dif.kind == nsm_pkg::NSM_K_SWAP);
          st_d        = nsm_pkg::NSM_BUSY;
        end
      end
      nsm_pkg::NSM_BUSY:
      begin
        cnt_d = cnt_q - `NSM_CYC_ONE;
        // Last busy cycle: the end pulses go out on the next edge
        if (cnt_q == `NSM_CYC_ONE)
        begin
          st_d   = nsm_pkg::NSM_DONE;
          done_d = 1'b1;
        end
      end
      nsm_pkg::NSM_DONE:
      begin
        // One spare cycle lets the register file settle the writeback
        // before the next issue can be taken
        st_d = nsm_pkg::NSM_IDLE;
      end
      default:
      begin
        st_d = nsm_pkg::NSM_IDLE; // Unused state code falls back to idle
      end
    endcase
    // Busy registered from the next state so the port needs no decode
    busy_d = (st_d == nsm_pkg::NSM_BUSY);
  end

  // Result next values: length, cycles, data and flags formed once at issue, then held until the next issue.
  // Only the swap writes back; the mask test leaves both operands alone.
  always_comb
  begin
    acc_d = take;
    len_d = len_q;
    cyc_d = cyc_q;
    wd_d  = wd_q;
    fl_d  = fl_q;
    // Write strobe rides with the completion pulse of a swap
    wr_d  = done_d && kind_swap_q;
    if (take)
    begin
      len_d = dif.len;
      cyc_d = dif.cycles;
      if (dif.kind == nsm_pkg::NSM_K_SWAP)
      begin
        wd_d = swp;
        fl_d = swap_flags(swp, FLAGS_IN);
      end
      else
      begin
        wd_d = DST_IN;                    // Operand kept intact; never written back
        fl_d = mask_flags(tst, FLAGS_IN);
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st_q        <= nsm_pkg::NSM_IDLE;
      cnt_q       <= `NSM_CYC_NONE;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      kind_swap_q <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      busy_q      <= busy_d;
      done_q      <= done_d;
      kind_swap_q <= kind_swap_d;
    end
  end

  // Result registers; reset shows a two-byte length and clear flags
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      acc_q <= 1'b0;
      len_q <= `NSM_LEN_2;
      cyc_q <= `NSM_CYC_NONE;
      wr_q  <= 1'b0;
      wd_q  <= `NSM_BYTE_ZERO;
      fl_q  <= `NSM_FLAGS_RST;
    end
    else
    begin
      acc_q <= acc_d;
      len_q <= len_d;
      cyc_q <= cyc_d;
      wr_q  <= wr_d;
      wd_q  <= wd_d;
      fl_q  <= fl_d;
    end
  end

  // Every output comes straight from a register, so the core sees no glitches
  assign BUSY      = busy_q;
  assign DONE      = done_q;
  assign ACCEPT    = acc_q;
  assign LEN       = len_q;
  assign CYCLES    = cyc_q;
  assign WR_EN     = wr_q;
  assign WR_DATA   = wd_q;
  assign FLAGS_OUT = fl_q;
endmodule

// ---- hdl/nsm_consts.svh ----
// Opcode, flag position and cycle count constants for the nibble swap and mask test unit
`ifndef NSM_CONSTS_SVH
`define NSM_CONSTS_SVH
`define NSM_OP_SWAP_R    8'hf0
`define NSM_OP_SWAP_IR   8'hf1
`define NSM_OP_IMT_RR_W  8'h62
`define NSM_OP_IMT_RIR_W 8'h63
`define NSM_OP_IMT_RR    8'h64
`define NSM_OP_IMT_RIR   8'h65
`define NSM_OP_IMT_RIM   8'h66
`define NSM_FLAG_C       7
`define NSM_FLAG_Z       6
`define NSM_FLAG_S       5
`define NSM_FLAG_V       4
`define NSM_FLAG_D       3
`define NSM_FLAG_H       2
`define NSM_SIGN_BIT     7
`define NSM_BYTE_ZERO    8'h00
`define NSM_FLAGS_RST    8'h00
`define NSM_LEN_2        2'h2
`define NSM_LEN_3        2'h3
`define NSM_CYC_4        3'h4
`define NSM_CYC_6        3'h6
`define NSM_CYC_ONE      3'h1
`define NSM_CYC_NONE     3'h0
`endif

// ---- hdl/nsm_pkg.sv ----
// Types shared by the nibble swap and mask test unit
package nsm_pkg;
  typedef enum logic [1:0] {NSM_IDLE, NSM_BUSY, NSM_DONE} nsm_state_t;
  typedef enum logic [1:0] {NSM_K_NONE, NSM_K_SWAP, NSM_K_IMT} nsm_kind_t;
endpackage

// ---- hdl/nsm_dec_if.sv ----
// Decode result carried from the opcode decoder to the execution top
`timescale 1ns/1ps
interface nsm_dec_if;
  nsm_pkg::nsm_kind_t kind;
  logic [1:0]         len;
  logic [2:0]         cycles;
  modport dec (output kind, output len, output cycles);
  modport use_side (input kind, input len, input cycles);
endinterface

// ---- hdl/nsm_decode.sv ----
// Opcode decoder giving kind, length and cycle count
`timescale 1ns/1ps
`include "nsm_consts.svh"
module nsm_decode (
  // Opcode in
  input  wire logic [7:0] opcode,
  // Decode out
  nsm_dec_if.dec          d
);
  // Plain table; unknown opcodes report no kind so the top ignores them
  always_comb
  begin
    d.kind   = nsm_pkg::NSM_K_NONE;
    d.len    = `NSM_LEN_2;
    d.cycles = `NSM_CYC_NONE;
    unique case (opcode)
      `NSM_OP_SWAP_R:
      begin
        d.kind   = nsm_pkg::NSM_K_SWAP;
        d.cycles = `NSM_CYC_4;
      end
      `NSM_OP_SWAP_IR:
      begin
        d.kind   = nsm_pkg::NSM_K_SWAP;
        d.cycles = `NSM_CYC_4;
      end
      `NSM_OP_IMT_RR_W:
      begin
        d.kind   = nsm_pkg::NSM_K_IMT;
        d.cycles = `NSM_CYC_4;
      end
      `NSM_OP_IMT_RIR_W:
      begin
        d.kind   = nsm_pkg::NSM_K_IMT;
        d.cycles = `NSM_CYC_6;
      end
      `NSM_OP_IMT_RR:
      begin
        d.kind   = nsm_pkg::NSM_K_IMT;
        d.len    = `NSM_LEN_3;
        d.cycles = `NSM_CYC_6;
      end
      `NSM_OP_IMT_RIR:
      begin
        d.kind   = nsm_pkg::NSM_K_IMT;
        d.len    = `NSM_LEN_3;
        d.cycles = `NSM_CYC_6;
      end
      `NSM_OP_IMT_RIM:
      begin
        d.kind   = nsm_pkg::NSM_K_IMT;
        d.len    = `NSM_LEN_3;
        d.cycles = `NSM_CYC_6;
      end
      default: ;
    endcase
  end
endmodule

// ---- test/nsm_regfile_model.sv ----
// Register file byte that takes the unit's writebacks
`timescale 1ns/1ps
module nsm_regfile_model (
  // Writeback in
  input  wire logic       clk,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored byte
  output logic      [7:0] reg_q
);
  // Only a write strobe may change the byte
  always_ff @(posedge clk)
    if (wr_en)
      reg_q <= wr_data;
endmodule

// ---- test/nsm_top_assertions.sv ----
// Port checker for the nibble swap and mask test unit
`timescale 1ns/1ps
module nsm_top_assertions (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       SRST,
  // Issue side
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] DST_IN,
  input wire logic [7:0] SRC_IN,
  input wire logic [7:0] FLAGS_IN,
  // Results
  input wire logic       BUSY,
  input wire logic       DONE,
  input wire logic       ACCEPT,
  input wire logic [1:0] LEN,
  input wire logic [2:0] CYCLES,
  input wire logic       WR_EN,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] FLAGS_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Accepted instruction, judged on the operands of the take edge
  sequence s_swap; ACCEPT && $past(OPCODE[7:4]) == 4'hf; endsequence
  sequence s_imt; ACCEPT && $past(OPCODE[7:4]) == 4'h6; endsequence
  // Two quiet cycles, then the end pulse with the write strobe
  sequence s_swap_end; !DONE [*2] ##1 (DONE && WR_EN); endsequence
  swap_data_a: assert property (s_swap |-> WR_DATA == {$past(DST_IN[3:0]), $past(DST_IN[7:4])})
    else $error("swap data wrong");
  swap_zero_a: assert property (s_swap |-> FLAGS_OUT[6] == (WR_DATA == 8'h00))
    else $error("swap zero flag wrong");
  swap_sign_a: assert property (s_swap |-> FLAGS_OUT[5] == WR_DATA[7])
    else $error("swap sign flag wrong");
  keep_dh_a: assert property (ACCEPT |-> FLAGS_OUT[3:2] == $past(FLAGS_IN[3:2]))
    else $error("decimal or half flag changed");
  mask_zero_a: assert property (s_imt |-> FLAGS_OUT[6] == ((~$past(DST_IN) & $past(SRC_IN)) == 8'h00))
    else $error("mask test zero flag wrong");
  cycle_count_a: assert property (ACCEPT |-> CYCLES == ($past(OPCODE) inside {8'h62, 8'hf0, 8'hf1} ? 3'h4 : 3'h6))
    else $error("cycle count wrong");
  byte_len_a: assert property (ACCEPT |-> LEN == ($past(OPCODE) inside {8'h64, 8'h65, 8'h66} ? 2'h3 : 2'h2))
    else $error("length wrong");
  swap_write_a: assert property (s_swap |=> s_swap_end)
    else $error("swap writeback timing wrong");
  busy_run_a: assert property (ACCEPT |-> BUSY)
    else $error("unit not busy after accept");
  refuse_busy_a: assert property (BUSY |=> !ACCEPT)
    else $error("issue taken while busy");
  done_pulse_a: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  no_write_a: assert property (s_imt |-> !WR_EN [*6])
    else $error("mask test wrote back");
endmodule

// ---- test/nsm_top_bench.sv ----
// Self-checking bench for the nibble swap and mask test unit
`timescale 1ns/1ps
module nsm_top_bench;
  logic       CLK = 1'b0, SRST = 1'b1, START = 1'b0;
  logic [7:0] OPCODE = 8'h00, DST_IN = 8'h00, SRC_IN = 8'h00, FLAGS_IN = 8'h00;
  logic       BUSY, DONE, ACCEPT, WR_EN;
  logic [1:0] LEN;
  logic [2:0] CYCLES;
  logic [7:0] WR_DATA, FLAGS_OUT, reg_q, lf = 8'h0d;
  logic [7:0] exp_q [$];
  logic [7:0] ops [7] = '{8'hf0, 8'hf1, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66};
  int         fails = 0, cmp_count = 0;
  // Clock and devices
  always #10 CLK = ~CLK;
  nsm_top DUT (.CLK, .SRST, .START, .OPCODE, .DST_IN, .SRC_IN, .FLAGS_IN, .BUSY, .DONE,
    .ACCEPT, .LEN, .CYCLES, .WR_EN, .WR_DATA, .FLAGS_OUT);
  nsm_regfile_model rf (.clk(CLK), .wr_en(WR_EN), .wr_data(WR_DATA), .reg_q(reg_q));
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (e !== g)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  // Issue one instruction; the reference result is worked out here
  task automatic run(logic [7:0] op, logic [7:0] d, logic [7:0] s, logic [7:0] f);
    logic [7:0] r, ef, old, ec;
    int n;
    logic sw;
    sw = op[7:4] == 4'hf;
    r = sw ? {d[3:0], d[7:4]} : (~d & s);
    ef = {f[7], r == 8'h00, r[7], sw & f[4], f[3:0]};
    ec = (op inside {8'h62, 8'hf0, 8'hf1}) ? 8'h04 : 8'h06;
    exp_q.push_back(ef);
    old = reg_q;
    @(negedge CLK);
    {START, OPCODE, DST_IN, SRC_IN, FLAGS_IN} = {1'b1, op, d, s, f};
    @(negedge CLK);
    n = 1;
    chk("accept", 8'h01, {7'h00, ACCEPT});
    chk("busy", 8'h01, {7'h00, BUSY});
    chk("len", (op inside {8'h64, 8'h65, 8'h66}) ? 8'h03 : 8'h02, {6'h00, LEN});
    chk("cycles", ec, {5'h00, CYCLES});
    chk("flags", exp_q.pop_front(), FLAGS_OUT);
    if (sw)
      chk("data", r, WR_DATA);
    // START stays high one more cycle: a busy unit must ignore it
    @(negedge CLK);
    START = 1'b0;
    n++;
    chk("refuse busy", 8'h00, {7'h00, ACCEPT});
    while (DONE !== 1'b1 && n < 8)
    begin
      @(negedge CLK);
      n++;
    end
    chk("done", ec, 8'(n));
    chk("write", {7'h00, sw}, {7'h00, WR_EN});
    chk("idle", 8'h00, {7'h00, BUSY});
    @(negedge CLK);
    chk("reg", sw ? r : old, reg_q);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #400000;
    fails++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(negedge CLK);
    SRST = 1'b0;
    run(8'hf0, 8'h3e, 8'h00, 8'hff);
    run(8'hf1, 8'h00, 8'h00, 8'h00);
    run(8'h62, 8'hc7, 8'h02, 8'h00);
    for (int i = 0; i < 70; i++)
      run(ops[i % 7], rnd(), rnd(), rnd());
    @(negedge CLK);
    {START, OPCODE} = {1'b1, 8'h72};
    @(negedge CLK);
    START = 1'b0;
    chk("refuse", 8'h00, {7'h00, ACCEPT});
    wrap_up();
  end
endmodule
bind nsm_top nsm_top_assertions chk_i (.CLK, .SRST, .OPCODE, .DST_IN, .SRC_IN, .FLAGS_IN,
  .BUSY, .DONE, .ACCEPT, .LEN, .CYCLES, .WR_EN, .WR_DATA, .FLAGS_OUT);
